// File: hw/pfiac_pkg.sv
/*
 Shared constants for the PCM frame input and attenuator control block:
 timing counts, sample and buffer sizes, loader states and the
 signal-presence test on companded samples.
 Assumes a 20 MHz core clock; every timing count below derives from it.
*/
package pfiac_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 20000000;
   localparam int CLK_PERIOD_NS = 1000000000 / CLK_HZ;
   localparam int CNT_W = 12;
   // Frame-start edges are blind for this long after reset (least time)
   localparam int INIT_BLANK_US = 100;
   localparam logic [CNT_W-1:0] INIT_BLANK_CYCLES =
      CNT_W'((INIT_BLANK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // High time of the load-detect output (least time)
   localparam int LOAD_PULSE_NS = 1000;
   localparam logic [CNT_W-1:0] LOAD_PULSE_CYCLES =
      CNT_W'((LOAD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // Length of one processing cycle (least time)
   localparam int PROC_NS = 5000;
   localparam logic [CNT_W-1:0] PROC_CYCLES =
      CNT_W'((PROC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // Longest wait for frame start after a load: one 8 kHz frame
   localparam int FRAME_WAIT_US = 125;
   localparam logic [CNT_W-1:0] FRAME_WAIT_CYCLES =
      CNT_W'((FRAME_WAIT_US * 1000) / CLK_PERIOD_NS);

   // ----------------------------------------------------------------
   // Samples, buffer and attenuator
   // ----------------------------------------------------------------
   localparam int SAMPLE_BITS = 8;
   localparam logic [3:0] SAMPLE_BITS_CNT = 4'h8;
   localparam int FIFO_WIDTH = 2 * SAMPLE_BITS;
   localparam int FIFO_DEPTH = 16;
   localparam int ATTEN_DB = 6;
   // Companded magnitude at or above this counts as signal
   localparam logic [6:0] SIG_THRESHOLD = 7'h10;

   typedef enum logic [1:0] {
      LD_IDLE = 2'b00,
      LD_PULSE = 2'b01,
      LD_WAIT = 2'b10
   } pfiac_ld_t;

   // Mu-law stores the magnitude inverted; silence codes as all ones
   function automatic logic signal_present(input logic [SAMPLE_BITS-1:0] sample);
      logic [6:0] mag;
      mag = ~sample[6:0];
      return (mag >= SIG_THRESHOLD);
   endfunction : signal_present

endpackage : pfiac_pkg

// File: hw/pfiac_fifo.sv
/*
 Synchronous FIFO with registered read data and valid/ready on both sides.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module pfiac_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [WIDTH-1:0] wr_data,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [WIDTH-1:0] rd_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   // Pop moves a word into the output register when it is free
   assign wr_ready = (count != DEPTH_CNT);
   assign push = wr_valid && wr_ready;
   assign pop = (count != '0) && (!rd_valid || rd_ready);

   // Storage array, no reset needed
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr] <= wr_data;
      end
   end

   // Pointers and fill level
   always_ff @(posedge clock) begin
      if (srst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop) rd_ptr <= rd_ptr + 1'b1;
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // Registered read side
   always_ff @(posedge clock) begin
      if (srst) begin
         rd_valid <= 1'b0;
         rd_data <= '0;
      end else if (pop) begin
         rd_valid <= 1'b1;
         rd_data <= mem[rd_ptr];
      end else if (rd_ready) begin
         rd_valid <= 1'b0;
      end
   end

   a_fifo_no_overflow: assert property (@(posedge clock) disable iff (srst)
      count <= DEPTH_CNT) else $error("fifo fill level above depth");

endmodule : pfiac_fifo

// File: hw/pfiac_link.sv
/*
 Serial sample capture on the bit clock: both PCM streams are shifted
 in on falling bit-clock edges after the frame sync rises.
 Assumes sync and data change on rising bit-clock edges; the finished
 word pair is announced by a toggle that the core clock synchronises.
*/
`timescale 1ns/1ps
module pfiac_link (
   input wire logic serial_bit_clock,
   input wire logic srst,
   input wire logic frame_sync_in,
   input wire logic transmit_pcm_in,
   input wire logic receive_pcm_in,
   output logic [pfiac_pkg::SAMPLE_BITS-1:0] word_tx,
   output logic [pfiac_pkg::SAMPLE_BITS-1:0] word_rx,
   output logic word_toggle
);
   logic rst_meta;
   logic link_rst;
   logic sync_prev;
   logic [3:0] bit_left;
   logic [pfiac_pkg::SAMPLE_BITS-1:0] sh_tx;
   logic [pfiac_pkg::SAMPLE_BITS-1:0] sh_rx;
   logic sync_rise;

   // Reset brought onto the bit clock; the clock must run during reset
   always_ff @(negedge serial_bit_clock) begin
      rst_meta <= srst;
      link_rst <= rst_meta;
   end

   assign sync_rise = frame_sync_in && !sync_prev;

   // Bit counter armed by the frame sync
   always_ff @(negedge serial_bit_clock) begin
      if (link_rst) begin
         sync_prev <= 1'b0;
         bit_left <= 4'h0;
      end else begin
         sync_prev <= frame_sync_in;
         if (sync_rise) begin
            bit_left <= pfiac_pkg::SAMPLE_BITS_CNT; // [R17]
         end else if (bit_left != 4'h0) begin
            bit_left <= bit_left - 4'h1;
         end
      end
   end

   // Both streams shifted MSB first on falling edges
   always_ff @(negedge serial_bit_clock) begin
      if (link_rst) begin
         sh_tx <= '0;
         sh_rx <= '0;
      end else if (!sync_rise && bit_left != 4'h0) begin
         sh_tx <= {sh_tx[6:0], transmit_pcm_in}; // [R12]
         sh_rx <= {sh_rx[6:0], receive_pcm_in}; // [R13]
      end
   end

   // Finished pair held stable for a whole frame while the toggle crosses
   always_ff @(negedge serial_bit_clock) begin
      if (link_rst) begin
         word_tx <= '0;
         word_rx <= '0;
         word_toggle <= 1'b0;
      end else if (!sync_rise && bit_left == 4'h1) begin
         word_tx <= {sh_tx[6:0], transmit_pcm_in}; // [R12] [R17]
         word_rx <= {sh_rx[6:0], receive_pcm_in}; // [R13] [R17]
         word_toggle <= !word_toggle;
      end
   end

   a_sync_arms_count: assert property (@(negedge serial_bit_clock) disable iff (link_rst) // [R17]
      sync_rise |=> bit_left == 4'h8) else $error("bit count not armed by frame sync");
   a_tx_word_bits: assert property (@(negedge serial_bit_clock) disable iff (link_rst) // [R12]
      (!sync_rise && bit_left == 4'h1) |=> word_tx == {$past(sh_tx[6:0]), $past(transmit_pcm_in)})
      else $error("transmit word not the last eight bits");
   a_rx_word_bits: assert property (@(negedge serial_bit_clock) disable iff (link_rst) // [R13]
      (!sync_rise && bit_left == 4'h1) |=> word_rx == {$past(sh_rx[6:0]), $past(receive_pcm_in)})
      else $error("receive word not the last eight bits");

endmodule : pfiac_link

// File: hw/pfiac_top.sv
/*
 Top of the PCM frame input and attenuator control block. Holds the
 bit-clock capture, the crossing into the core clock, the sample buffer,
 the load-detect output, frame-start detection with its start-up
 blanking, and the per-frame attenuator decision.
 Assumes a 20 MHz core clock, a free bit clock from the codec while
 reset is held, and frame_start_in wired back from load_detect_out.
*/
`timescale 1ns/1ps

// How it works
// R1 - With receive signal and no transmit signal the transmit output attenuator is chosen.
// R2 - With no receive signal, or signal on both paths, the receive input attenuator is chosen.
// R3 - While attenuation is enabled exactly one attenuator is active, each worth 6 dB; both stay off from reset release to the first accepted fall.
// R4 - A high attenuator_control disables attenuation, low enables it; slaves hold it low.
// R5 - The controller is advised to hold attenuator_control low while cancelling echo.
// R6 - attenuator_control is taken only at a frame_start_in fall or at reset release.
// R7 - Each falling edge of frame_start_in starts one processing cycle per 8 kHz frame.
// R8 - For 100 us after reset any frame_start_in transition is ignored.
// R9 - The board ties frame_start_in to the master's load_detect_out.
// R10 - load_detect_out rises once both serial samples sit in the internal registers.
// R11 - In a cascade only the master's load_detect_out is used, slave outputs stay open.
// R12 - transmit_pcm_in is sampled on every falling bit-clock edge of the frame; the code samples only the 8 falling edges after the sync edge.
// R13 - receive_pcm_in is sampled on every falling bit-clock edge of the frame; the code samples only the 8 falling edges after the sync edge.
// R14 - The bit clock runs between 64 and 2048 kHz.
// R15 - frame_sync_in recurs at 8 kHz.
// R16 - The board sets master_slave_select low for master or single and high for slave.
// R17 - Each frame carries one 8-bit sample per path, MSB first, from the edge after sync.
module pfiac_top (
   input wire logic clock,
   input wire logic srst,
   input wire logic serial_bit_clock,
   input wire logic frame_sync_in,
   input wire logic transmit_pcm_in,
   input wire logic receive_pcm_in,
   input wire logic frame_start_in,
   input wire logic attenuator_control,
   output logic load_detect_out,
   output logic proc_start,
   output logic proc_busy,
   output logic atten_enabled,
   output logic tx_atten_active,
   output logic rx_atten_active,
   output logic [pfiac_pkg::SAMPLE_BITS-1:0] frame_tx_sample,
   output logic [pfiac_pkg::SAMPLE_BITS-1:0] frame_rx_sample,
   output logic sample_overrun
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [pfiac_pkg::SAMPLE_BITS-1:0] word_tx;
   logic [pfiac_pkg::SAMPLE_BITS-1:0] word_rx;
   logic word_toggle;
   logic tog_meta;
   logic tog_sync;
   logic tog_prev;
   logic fs_meta;
   logic fs_sync;
   logic fs_prev;
   logic att_meta;
   logic att_sync;
   logic srst_prev;
   logic reset_release;
   logic [pfiac_pkg::CNT_W-1:0] blank_cnt;
   logic blanked;
   logic fs_fall;
   logic word_evt;
   logic fifo_wr_ready;
   logic fifo_rd_valid;
   logic fifo_rd_ready;
   logic [pfiac_pkg::FIFO_WIDTH-1:0] fifo_rd_data;
   logic rd_fire;
   pfiac_pkg::pfiac_ld_t ld_state;
   logic [pfiac_pkg::CNT_W-1:0] ld_cnt;
   logic [pfiac_pkg::CNT_W-1:0] proc_cnt;
   logic tx_sig;
   logic rx_sig;
   logic [pfiac_pkg::CNT_W-1:0] since_release;

   // ----------------------------------------------------------------
   // Bit-clock capture
   // ----------------------------------------------------------------
   // Both streams are taken on the bit clock's own falling edges
   pfiac_link u_link (
      .serial_bit_clock(serial_bit_clock),
      .srst(srst),
      .frame_sync_in(frame_sync_in),
      .transmit_pcm_in(transmit_pcm_in), // [R12]
      .receive_pcm_in(receive_pcm_in), // [R13]
      .word_tx(word_tx),
      .word_rx(word_rx),
      .word_toggle(word_toggle)
   );

   // ----------------------------------------------------------------
   // Crossings and pin synchronisers
   // ----------------------------------------------------------------
   // Two flops per asynchronous input; only the second stage is read
   always_ff @(posedge clock) begin
      fs_meta <= frame_start_in;
      fs_sync <= fs_meta;
      att_meta <= attenuator_control;
      att_sync <= att_meta;
      srst_prev <= srst;
   end

   // Toggle synchroniser and edge history; the toggle stages are cleared
   // so an unknown link toggle at start-up cannot fake a buffer push
   always_ff @(posedge clock) begin
      if (srst) begin
         tog_meta <= 1'b0;
         tog_sync <= 1'b0;
         tog_prev <= 1'b0;
         fs_prev <= 1'b0;
      end else begin
         tog_meta <= word_toggle;
         tog_sync <= tog_meta;
         tog_prev <= tog_sync;
         fs_prev <= fs_sync;
      end
   end

   // The word registers sit still for a frame, so a synced toggle
   // is enough to qualify the multi-bit crossing
   assign word_evt = tog_sync ^ tog_prev;
   assign reset_release = srst_prev && !srst;

   // ----------------------------------------------------------------
   // Start-up blanking and frame start
   // ----------------------------------------------------------------
   // Down-counter covering internal initialisation after reset
   always_ff @(posedge clock) begin
      if (srst) begin
         blank_cnt <= pfiac_pkg::INIT_BLANK_CYCLES; // [R8]
      end else if (blank_cnt != '0) begin
         blank_cnt <= blank_cnt - 1'b1;
      end
   end

   assign blanked = (blank_cnt != '0);
   // A fall during blanking is dropped, not deferred
   assign fs_fall = fs_prev && !fs_sync && !blanked; // [R7] [R8]

   // ----------------------------------------------------------------
   // Sample buffer
   // ----------------------------------------------------------------
   // Absorbs frames that arrive while a processing cycle still runs
   pfiac_fifo #(
      .WIDTH(pfiac_pkg::FIFO_WIDTH),
      .DEPTH(pfiac_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .srst(srst),
      .wr_valid(word_evt),
      .wr_ready(fifo_wr_ready),
      .wr_data({word_tx, word_rx}),
      .rd_valid(fifo_rd_valid),
      .rd_ready(fifo_rd_ready),
      .rd_data(fifo_rd_data)
   );

   // The link cannot be stalled, so a full buffer loses the new pair
   always_ff @(posedge clock) begin
      if (srst) begin
         sample_overrun <= 1'b0;
      end else if (word_evt && !fifo_wr_ready) begin
         sample_overrun <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Sample load and load detect
   // ----------------------------------------------------------------
   // Drain stalls while a cycle runs or a load awaits its frame start
   assign fifo_rd_ready = (ld_state == pfiac_pkg::LD_IDLE) && !proc_busy;
   assign rd_fire = fifo_rd_valid && fifo_rd_ready;

   // Loader sequence: take a pair, pulse load detect, wait for start
   always_ff @(posedge clock) begin
      if (srst) begin
         ld_state <= pfiac_pkg::LD_IDLE;
         ld_cnt <= '0;
         load_detect_out <= 1'b0;
      end else begin
         case (ld_state)
            pfiac_pkg::LD_IDLE: begin
               if (rd_fire) begin
                  load_detect_out <= 1'b1; // [R10]
                  ld_cnt <= pfiac_pkg::LOAD_PULSE_CYCLES - 1'b1;
                  ld_state <= pfiac_pkg::LD_PULSE;
               end
            end
            pfiac_pkg::LD_PULSE: begin
               if (ld_cnt == '0) begin
                  // The falling edge here is what frame start sees
                  load_detect_out <= 1'b0;
                  ld_cnt <= pfiac_pkg::FRAME_WAIT_CYCLES;
                  ld_state <= pfiac_pkg::LD_WAIT;
               end else begin
                  ld_cnt <= ld_cnt - 1'b1;
               end
            end
            pfiac_pkg::LD_WAIT: begin
               // Timeout keeps the loader alive if the start was blanked
               if (fs_fall || ld_cnt == '0) begin
                  ld_state <= pfiac_pkg::LD_IDLE;
               end else begin
                  ld_cnt <= ld_cnt - 1'b1;
               end
            end
            default: begin
               ld_state <= pfiac_pkg::LD_IDLE;
               load_detect_out <= 1'b0;
            end
         endcase
      end
   end

   // Internal sample registers loaded with the buffered pair
   always_ff @(posedge clock) begin
      if (srst) begin
         frame_tx_sample <= 8'hFF;
         frame_rx_sample <= 8'hFF;
      end else if (rd_fire) begin
         frame_tx_sample <= fifo_rd_data[15:8]; // [R10]
         frame_rx_sample <= fifo_rd_data[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Processing cycle
   // ----------------------------------------------------------------
   // Every accepted fall restarts the cycle, even one still running
   always_ff @(posedge clock) begin
      if (srst) begin
         proc_start <= 1'b0;
         proc_busy <= 1'b0;
         proc_cnt <= '0;
      end else begin
         proc_start <= fs_fall; // [R7]
         if (fs_fall) begin
            proc_busy <= 1'b1;
            proc_cnt <= pfiac_pkg::PROC_CYCLES - 1'b1;
         end else if (proc_cnt != '0) begin
            proc_cnt <= proc_cnt - 1'b1;
         end else begin
            proc_busy <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Attenuator control
   // ----------------------------------------------------------------
   // Control level taken only at reset release or an accepted fall;
   // low enables attenuation
   always_ff @(posedge clock) begin
      if (srst) begin
         atten_enabled <= 1'b0;
      end else if (reset_release || fs_fall) begin
         atten_enabled <= !att_sync; // [R4] [R6]
      end
   end

   assign tx_sig = pfiac_pkg::signal_present(frame_tx_sample);
   assign rx_sig = pfiac_pkg::signal_present(frame_rx_sample);

   // Path choice per frame; one of the two 6 dB stages is on when the fall finds att_sync low
   always_ff @(posedge clock) begin
      if (srst) begin
         tx_atten_active <= 1'b0;
         rx_atten_active <= 1'b0;
      end else if (fs_fall) begin
         tx_atten_active <= !att_sync && rx_sig && !tx_sig; // [R1] [R3]
         rx_atten_active <= !att_sync && !(rx_sig && !tx_sig); // [R2] [R3]
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_tx_atten_cause: assert property (@(posedge clock) disable iff (srst) // [R1]
      proc_start |-> tx_atten_active == (atten_enabled && $past(rx_sig) && !$past(tx_sig)))
      else $error("transmit attenuator choice wrong");
   a_rx_atten_cause: assert property (@(posedge clock) disable iff (srst) // [R2]
      proc_start |-> rx_atten_active == (atten_enabled && !($past(rx_sig) && !$past(tx_sig))))
      else $error("receive attenuator choice wrong");
   a_one_atten_on: assert property (@(posedge clock) disable iff (srst) // [R3]
      proc_start |-> (tx_atten_active ^ rx_atten_active) == atten_enabled)
      else $error("attenuators not exclusive");
   a_att_capture: assert property (@(posedge clock) disable iff (srst) // [R4]
      fs_fall |=> atten_enabled == !$past(att_sync))
      else $error("control level not taken at frame start");
   a_att_hold: assert property (@(posedge clock) disable iff (srst) // [R6]
      (!fs_fall && !reset_release) |=> $stable(atten_enabled))
      else $error("control level changed between frame starts");
   a_start_pulse: assert property (@(posedge clock) disable iff (srst) // [R7]
      fs_fall |=> proc_start && proc_busy ##1 !proc_start)
      else $error("frame start did not start one cycle");
   a_blank_ignore: assert property (@(posedge clock) disable iff (srst) // [R8]
      blanked |=> !proc_start) else $error("frame start taken during blanking");
   // Cycles since reset release, saturating; a ruler kept apart from the blanking counter
   always_ff @(posedge clock) begin
      if (srst) begin
         since_release <= '0;
      end else if (since_release != '1) begin
         since_release <= since_release + 1'b1;
      end
   end

   a_blank_length: assert property (@(posedge clock) disable iff (srst) // [R8]
      blanked == (since_release < pfiac_pkg::INIT_BLANK_CYCLES))
      else $error("blanking length wrong");
   a_load_cause: assert property (@(posedge clock) disable iff (srst) // [R10]
      $rose(load_detect_out) |-> $past(rd_fire) && frame_tx_sample == $past(fifo_rd_data[15:8]))
      else $error("load detect without loaded samples");

endmodule : pfiac_top

// File: dv/pfiac_codec_model.sv
/*
 Codec-side model: bit clock, frame sync and the two serial sample streams.
 Assumes the block samples both streams on falling bit-clock edges.
*/
`timescale 1ns/1ps
module pfiac_codec_model (
   output logic serial_bit_clock,
   output logic frame_sync_in,
   output logic transmit_pcm_in,
   output logic receive_pcm_in
);
   // ----------------------------------------------------------------
   // Bit clock and idle levels
   // ----------------------------------------------------------------
   // Runs free like a codec clock; far faster than a real one to keep runs short
   initial begin
      serial_bit_clock = 1'b0;
      frame_sync_in = 1'b0;
      transmit_pcm_in = 1'b0;
      receive_pcm_in = 1'b0;
   end
   always #32 serial_bit_clock = ~serial_bit_clock;

   // ----------------------------------------------------------------
   // One frame: sync for one bit, then 8 bits per path
   // ----------------------------------------------------------------
   // Changes on rising edges so each bit is settled at the falling edge
   task automatic send_frame(input logic [7:0] tx, input logic [7:0] rx);
      int i;
      @(posedge serial_bit_clock);
      frame_sync_in <= 1'b1;
      for (i = 7; i >= 0; i--) begin
         @(posedge serial_bit_clock);
         frame_sync_in <= 1'b0;
         transmit_pcm_in <= tx[i]; // MSB first from the edge after sync
         receive_pcm_in <= rx[i];
      end
      @(posedge serial_bit_clock);
      // Released lines show the inverse, so no stale bit can pass for data
      transmit_pcm_in <= ~tx[0];
      receive_pcm_in <= ~rx[0];
   endtask : send_frame
endmodule : pfiac_codec_model

// File: dv/tb_top.sv
/*
 Self-checking bench for the PCM frame input and attenuator control top.
 Assumes the codec model drives the link and frame start loops back from
 load detect except where a scenario drives it directly.
*/
`timescale 1ns/1ps
module tb_top;
   logic clock, srst, frame_start_drv, loop_back, attenuator_control, frame_start_in;
   logic serial_bit_clock, frame_sync_in, transmit_pcm_in, receive_pcm_in;
   logic load_detect_out, proc_start, proc_busy, atten_enabled;
   logic tx_atten_active, rx_atten_active, sample_overrun;
   logic [pfiac_pkg::SAMPLE_BITS-1:0] frame_tx_sample, frame_rx_sample;
   int n_fail, compares, n_start;

   // ----------------------------------------------------------------
   // Clock, wiring and instances
   // ----------------------------------------------------------------
   always #25 clock = ~clock;
   // Board wiring: frame start fed back from load detect
   assign frame_start_in = loop_back ? load_detect_out : frame_start_drv;
   always @(posedge clock) if (proc_start === 1'b1) n_start++;

   pfiac_codec_model pfiac_codec_model_i (.serial_bit_clock(serial_bit_clock),
      .frame_sync_in(frame_sync_in), .transmit_pcm_in(transmit_pcm_in),
      .receive_pcm_in(receive_pcm_in));
   pfiac_top pfiac_top_i (.clock(clock), .srst(srst), .serial_bit_clock(serial_bit_clock),
      .frame_sync_in(frame_sync_in), .transmit_pcm_in(transmit_pcm_in),
      .receive_pcm_in(receive_pcm_in), .frame_start_in(frame_start_in),
      .attenuator_control(attenuator_control), .load_detect_out(load_detect_out),
      .proc_start(proc_start), .proc_busy(proc_busy), .atten_enabled(atten_enabled),
      .tx_atten_active(tx_atten_active), .rx_atten_active(rx_atten_active),
      .frame_tx_sample(frame_tx_sample), .frame_rx_sample(frame_rx_sample),
      .sample_overrun(sample_overrun));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Bounded wait for load detect (0) or processing start (1), sampled settled
   task automatic wait_for(input logic sel);
      int k;
      for (k = 0; k < 400 && (sel ? proc_start : load_detect_out) !== 1'b1; k++) begin
         @(posedge clock);
         #1;
      end
   endtask : wait_for

   function automatic logic sig(input logic [7:0] s);
      return (~s[6:0]) >= 7'h10; // Inverted mu-law magnitude
   endfunction : sig

   task automatic run_frame(input logic [7:0] tx, input logic [7:0] rx, input logic off);
      logic st, sr;
      logic [1:0] exp;
      st = sig(tx);
      sr = sig(rx);
      exp = off ? 2'b00 : ((sr && !st) ? 2'b10 : 2'b01);
      @(posedge clock);
      attenuator_control <= off; // Low while cancelling unless disable is meant
      repeat (4) @(posedge clock);
      pfiac_codec_model_i.send_frame(tx, rx);
      wait_for(1'b0);
      chk("load_detect_out", 8'h01, {7'h00, load_detect_out});
      chk("frame_tx_sample", tx, frame_tx_sample);
      chk("frame_rx_sample", rx, frame_rx_sample);
      wait_for(1'b1);
      chk("proc_start", 8'h01, {7'h00, proc_start});
      chk("atten_enabled", {7'h00, !off}, {7'h00, atten_enabled});
      if (off || sr || !st) chk("atten_sel", {6'h00, exp},
         {6'h00, tx_atten_active, rx_atten_active});
      if (!off) chk("one_active", 8'h01, {7'h00, tx_atten_active ^ rx_atten_active});
      repeat (110) @(posedge clock);
   endtask : run_frame

   task automatic end_of_test();
      if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   // Reset values, capture at release, frame start blind after reset
   task automatic t_reset();
      #1;
      chk("reset_outs", 8'h00, {1'b0, load_detect_out, proc_start, proc_busy, atten_enabled,
         tx_atten_active, rx_atten_active, sample_overrun});
      chk("reset_tx_sample", 8'hFF, frame_tx_sample);
      @(posedge clock);
      srst <= 1'b0;
      repeat (300) @(posedge clock);
      #1;
      chk("atten_at_release", 8'h01, {7'h00, atten_enabled});
      @(posedge clock);
      frame_start_drv <= 1'b1;
      repeat (20) @(posedge clock);
      frame_start_drv <= 1'b0;
      n_start = 0;
      repeat (100) @(posedge clock);
      chk("blank_starts", 8'h00, 8'(n_start));
      repeat (1800) @(posedge clock);
      loop_back <= 1'b1;
   endtask : t_reset

   // Every signal case, path checked in all but transmit-only, then a pin change between frames that must not land
   task automatic t_atten();
      run_frame(8'hFF, 8'h00, 1'b0);
      run_frame(8'hFF, 8'hFF, 1'b0);
      run_frame(8'h00, 8'h00, 1'b0);
      run_frame(8'h00, 8'hFF, 1'b0);
      attenuator_control <= 1'b1;
      repeat (50) @(posedge clock);
      chk("atten_between_frames", 8'h01, {7'h00, atten_enabled});
      run_frame(8'hFF, 8'h00, 1'b1);
   endtask : t_atten

   // Fill the buffer past full with frame start held, then drain in order
   task automatic t_overrun();
      int i;
      frame_start_drv <= 1'b1;
      loop_back <= 1'b0;
      attenuator_control <= 1'b0;
      for (i = 0; i < 20; i++) pfiac_codec_model_i.send_frame(8'(i), ~8'(i));
      repeat (20) @(posedge clock);
      chk("sample_overrun", 8'h01, {7'h00, sample_overrun});
      n_start = 0;
      loop_back <= 1'b1;
      repeat (3200) @(posedge clock);
      chk("drained_starts", 8'h12, 8'(n_start));
      chk("last_tx_sample", 8'h11, frame_tx_sample);
      chk("last_rx_sample", 8'hEE, frame_rx_sample);
      chk("overrun_sticky", 8'h01, {7'h00, sample_overrun});
   endtask : t_overrun

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      clock = 1'b0;
      srst = 1'b1;
      frame_start_drv = 1'b0;
      loop_back = 1'b0;
      attenuator_control = 1'b0;
      n_fail = 0;
      compares = 0;
      n_start = 0;
      repeat (4) @(posedge clock);
      t_reset();
      t_atten();
      t_overrun();
      end_of_test();
   end

   // Tests need about 7000 clocks; a hang is cut well beyond that
   initial begin
      repeat (20000) @(posedge clock);
      n_fail++;
      end_of_test();
   end
endmodule : tb_top
